// File: core/flash_link_pkg.sv
// shared constants and carrier types for the single-wire flash LED programming block
package flash_link_pkg;

    // register addresses
    localparam logic [1:0] ADDR_TORCH_CURRENT = 2'h0;
    localparam logic [1:0] ADDR_SAFETY_TIMER  = 2'h1;
    localparam logic [1:0] ADDR_CHANNEL_SEL   = 2'h2;
    localparam logic [1:0] ADDR_RATIO         = 2'h3;

    // burst edge counts
    localparam logic [4:0] EDGE_DATA_MAX  = 5'h10;
    localparam logic [4:0] EDGE_ADDR_BASE = 5'h11;
    localparam logic [4:0] EDGE_ADDR_LAST = 5'h14;
    localparam logic [4:0] EDGE_SATURATE  = 5'h15;
    localparam logic [4:0] EDGE_ONE       = 5'h01;

    // stored codes are data minus one; cleared value is zero
    localparam logic [3:0] CODE_CLEAR         = 4'h0;
    localparam logic [3:0] TORCH_STEP_DEFAULT = 4'h0;
    localparam logic [3:0] TIMER_FULL_DEFAULT = 4'h0;
    localparam logic [3:0] CHANNEL_DEFAULT    = 4'h3;
    localparam logic [3:0] RATIO_DEFAULT      = 4'h3;
    localparam logic [3:0] CODE_OFF           = 4'hF;
    localparam logic [3:0] CHANNEL_NONE       = 4'h0;
    localparam logic [3:0] CHANNEL_B_ONLY     = 4'h1;
    localparam logic [3:0] CHANNEL_A_ONLY     = 4'h2;
    localparam logic [3:0] CHANNEL_BOTH       = 4'h3;

    // timing
    localparam int unsigned CLK_FREQ_MHZ  = 125;
    localparam int unsigned LATCH_TIME_US = 500;
    localparam int unsigned OFF_TIME_US   = 500;
    localparam int unsigned CNT_W         = 17;
    localparam logic [CNT_W-1:0] LATCH_CYCLES = CNT_W'(LATCH_TIME_US * CLK_FREQ_MHZ);
    localparam logic [CNT_W-1:0] OFF_CYCLES   = CNT_W'(OFF_TIME_US * CLK_FREQ_MHZ);

    typedef struct packed {
        logic ctrl;
        logic flash;
        logic inhibit;
    } pin_bus_t;

    typedef struct packed {
        pin_bus_t stage1;
        pin_bus_t stage2;
        pin_bus_t stage3;
        pin_bus_t stable;
    } sync_state_t;

    typedef struct packed {
        logic [3:0] torch_step;
        logic [3:0] timer_frac;
        logic [3:0] channel_sel;
        logic [3:0] ratio_sel;
    } settings_t;

    localparam settings_t SETTINGS_CLEAR = '{CODE_CLEAR, CODE_CLEAR, CODE_CLEAR, CODE_CLEAR};
    localparam settings_t SETTINGS_DEFAULT =
        '{TORCH_STEP_DEFAULT, TIMER_FULL_DEFAULT, CHANNEL_DEFAULT, RATIO_DEFAULT};

    typedef struct packed {
        logic             enabled;
        logic             ctrl_prev;
        logic [4:0]       edges;
        logic [CNT_W-1:0] high_cnt;
        logic [CNT_W-1:0] low_cnt;
        logic [1:0]       addr;
        settings_t        regs;
        logic             written;
        logic             torch_locked;
        logic             flash_active;
        logic             torch_mode;
        logic             sink_a;
        logic             sink_b;
        logic             torch_off;
        logic             inhibit_active;
    } core_state_t;

    localparam core_state_t CORE_RESET = '{
        enabled:        1'b0,
        ctrl_prev:      1'b0,
        edges:          5'h00,
        high_cnt:       '0,
        low_cnt:        '0,
        addr:           ADDR_TORCH_CURRENT,
        regs:           SETTINGS_CLEAR,
        written:        1'b0,
        torch_locked:   1'b0,
        flash_active:   1'b0,
        torch_mode:     1'b0,
        sink_a:         1'b0,
        sink_b:         1'b0,
        torch_off:      1'b0,
        inhibit_active: 1'b0
    };

endpackage

// File: core/pin_sync.sv
// three-stage synchroniser with agreement filter for the asynchronous pins
`timescale 1ns/10ps
module pin_sync (
    input  wire logic                     mclk,
    input  wire logic                     rstn,
    input  wire logic                     clk_en,
    input  wire flash_link_pkg::pin_bus_t pins_async,
    output flash_link_pkg::pin_bus_t      pins_stable
);
    import flash_link_pkg::*;

    sync_state_t q;
    sync_state_t d;

    always_comb begin
        d        = q;
        d.stage1 = pins_async;
        d.stage2 = q.stage1;
        d.stage3 = q.stage2;
        // a change counts only once stages two and three agree
        if (q.stage2.ctrl == q.stage3.ctrl) begin
            d.stable.ctrl = q.stage3.ctrl;
        end
        if (q.stage2.flash == q.stage3.flash) begin
            d.stable.flash = q.stage3.flash;
        end
        if (q.stage2.inhibit == q.stage3.inhibit) begin
            d.stable.inhibit = q.stage3.inhibit;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign pins_stable = q.stable;

endmodule

// File: core/flash_link_core.sv
// single-wire edge-counting programming logic and setting registers of the flash LED driver
`timescale 1ns/10ps
module flash_link_core #(
    parameter logic [flash_link_pkg::CNT_W-1:0] LATCH_CNT = flash_link_pkg::LATCH_CYCLES,
    parameter logic [flash_link_pkg::CNT_W-1:0] OFF_CNT   = flash_link_pkg::OFF_CYCLES
) (
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire logic                  clk_en,
    input  wire logic                  ctrl_pin,
    input  wire logic                  flash_trigger,
    input  wire logic                  flash_inhibit_pin,
    output flash_link_pkg::settings_t  settings,
    output logic [1:0]                 selected_addr,
    output logic                       device_enabled,
    output logic                       torch_mode,
    output logic                       flash_active,
    output logic                       sink_channel_a,
    output logic                       sink_channel_b,
    output logic                       torch_off,
    output logic                       inhibit_active
);
    import flash_link_pkg::*;

    pin_bus_t    pins_async;
    pin_bus_t    pins;
    core_state_t q;
    core_state_t d;
    logic        ctrl_rise;
    logic        flash_now;
    logic        latch_now;

    // channel enables in torch mode: {a, b}
    function automatic logic [1:0] decode_channels(input logic [3:0] sel);
        logic [1:0] ab;
        ab = 2'b00;
        unique case (sel)
            CHANNEL_NONE:   ab = 2'b00;
            CHANNEL_B_ONLY: ab = 2'b01;
            CHANNEL_A_ONLY: ab = 2'b10;
            CHANNEL_BOTH:   ab = 2'b11;
            default:        ab = 2'b00;
        endcase
        return ab;
    endfunction

    // burst length to stored code (data minus one)
    function automatic logic [3:0] edges_to_code(input logic [4:0] edges);
        logic [4:0] diff;
        diff = edges - EDGE_ONE;
        return diff[3:0];
    endfunction

    assign pins_async = '{ctrl: ctrl_pin, flash: flash_trigger, inhibit: flash_inhibit_pin};

    pin_sync u_pin_sync (
        .mclk        (mclk),
        .rstn        (rstn),
        .clk_en      (clk_en),
        .pins_async  (pins_async),
        .pins_stable (pins)
    );

    always_comb begin
        logic [1:0] ab;
        ab        = 2'b00;
        d         = q;
        ctrl_rise = pins.ctrl & ~q.ctrl_prev;
        latch_now = 1'b0;
        flash_now = pins.flash & q.enabled;
        d.ctrl_prev = pins.ctrl;

        if (pins.ctrl) begin
            d.low_cnt = '0;
            if (ctrl_rise) begin
                d.high_cnt = '0;
                d.enabled  = 1'b1;
                if (q.edges != EDGE_SATURATE) begin
                    d.edges = q.edges + EDGE_ONE;
                end
            end else if (q.high_cnt != LATCH_CNT) begin
                d.high_cnt = q.high_cnt + CNT_W'(1);
                latch_now  = (q.high_cnt == LATCH_CNT - CNT_W'(1)) && (q.edges != 5'h00);
            end
        end else begin
            d.high_cnt = '0;
            if (q.low_cnt != OFF_CNT) begin
                d.low_cnt = q.low_cnt + CNT_W'(1);
            end
        end

        if (latch_now) begin
            d.edges = 5'h00;
            if (q.edges <= EDGE_DATA_MAX) begin
                d.written = 1'b1;
                unique case (q.addr)
                    ADDR_TORCH_CURRENT: d.regs.torch_step  = edges_to_code(q.edges);
                    ADDR_SAFETY_TIMER:  d.regs.timer_frac  = edges_to_code(q.edges);
                    ADDR_CHANNEL_SEL:   d.regs.channel_sel = edges_to_code(q.edges);
                    ADDR_RATIO:         d.regs.ratio_sel   = edges_to_code(q.edges);
                endcase
            end else if (q.edges <= EDGE_ADDR_LAST) begin
                d.addr = 2'(q.edges - EDGE_ADDR_BASE);
            end
            // longer bursts are dropped with no effect
        end

        // flash trigger edges
        if (flash_now && !q.flash_active) begin
            d.torch_locked = 1'b1;
            if (!q.written && !latch_now) begin
                d.regs = SETTINGS_DEFAULT;
            end
        end
        if (!flash_now && q.flash_active) begin
            d.regs.timer_frac = TIMER_FULL_DEFAULT;
        end
        d.flash_active = flash_now;

        // long low: shutdown clears everything
        if (!pins.ctrl && q.low_cnt == OFF_CNT - CNT_W'(1)) begin
            d.enabled      = 1'b0;
            d.regs         = SETTINGS_CLEAR;
            d.addr         = ADDR_TORCH_CURRENT;
            d.edges        = 5'h00;
            d.written      = 1'b0;
            d.torch_locked = 1'b0;
            d.flash_active = 1'b0;
        end

        d.torch_mode = d.enabled & ~d.torch_locked & ~d.flash_active;
        if (d.flash_active) begin
            ab = 2'b11;
        end else if (d.torch_mode) begin
            ab = decode_channels(d.regs.channel_sel);
        end
        d.sink_a         = ab[1];
        d.sink_b         = ab[0];
        d.torch_off      = (d.regs.ratio_sel == CODE_OFF) | (d.regs.torch_step == CODE_OFF);
        d.inhibit_active = d.flash_active & pins.inhibit;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= CORE_RESET;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign settings       = q.regs;
    assign selected_addr  = q.addr;
    assign device_enabled = q.enabled;
    assign torch_mode     = q.torch_mode;
    assign flash_active   = q.flash_active;
    assign sink_channel_a = q.sink_a;
    assign sink_channel_b = q.sink_b;
    assign torch_off      = q.torch_off;
    assign inhibit_active = q.inhibit_active;

endmodule

// File: sim/flash_link_checker.sv
// assertion checker for the flash link core ports
`timescale 1ns/10ps
module flash_link_checker
    import flash_link_pkg::*;
#(
    parameter logic [CNT_W-1:0] LATCH_CNT = LATCH_CYCLES,
    parameter logic [CNT_W-1:0] OFF_CNT   = OFF_CYCLES
) (
    input wire logic                      mclk,
    input wire logic                      rstn,
    input wire logic                      clk_en,
    input wire logic                      ctrl_pin,
    input wire logic                      flash_trigger,
    input wire logic                      flash_inhibit_pin,
    input wire flash_link_pkg::settings_t settings,
    input wire logic [1:0]                selected_addr,
    input wire logic                      device_enabled,
    input wire logic                      torch_mode,
    input wire logic                      flash_active,
    input wire logic                      sink_channel_a,
    input wire logic                      sink_channel_b,
    input wire logic                      torch_off,
    input wire logic                      inhibit_active
);
    logic [CNT_W-1:0] low_run_q;
    // raw low time of the control pin, saturating
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            low_run_q <= '0;
        end else if (ctrl_pin) begin
            low_run_q <= '0;
        end else if (clk_en && low_run_q != '1) begin
            low_run_q <= low_run_q + 17'h1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence flash_held;
        flash_active ##1 flash_active;
    endsequence
    sequence flash_end;
        $fell(flash_active);
    endsequence
    a_shutdown_clears: assert property (low_run_q == OFF_CNT + 17'hA |->
        !device_enabled && settings == '0 && selected_addr == 2'h0) else $error("state kept after long low");
    a_flash_both_sinks: assert property (flash_held |-> sink_channel_a && sink_channel_b)
        else $error("sink off in flash");
    a_flash_ends_torch: assert property (flash_held |-> !torch_mode) else $error("torch in flash");
    a_torch_stays_off: assert property (flash_end |-> (!torch_mode)[*8]) else $error("torch resumed");
    a_timer_reverts: assert property (flash_end |-> ##[0:2] settings.timer_frac == TIMER_FULL_DEFAULT)
        else $error("timer not reverted");
    a_ratio_off_flag: assert property ((settings.ratio_sel == CODE_OFF)[*2] |-> torch_off)
        else $error("torch not off");
    a_chan_b_only: assert property ((torch_mode && settings.channel_sel == CHANNEL_B_ONLY)[*2] |->
        !sink_channel_a && sink_channel_b) else $error("b only decode");
    a_chan_none: assert property ((torch_mode && settings.channel_sel == CHANNEL_NONE)[*2] |->
        !sink_channel_a && !sink_channel_b) else $error("none decode");
endmodule
bind flash_link_core flash_link_checker #(.LATCH_CNT(LATCH_CNT), .OFF_CNT(OFF_CNT)) chk_i (
    .mclk(mclk), .rstn(rstn), .clk_en(clk_en), .ctrl_pin(ctrl_pin), .flash_trigger(flash_trigger),
    .flash_inhibit_pin(flash_inhibit_pin), .settings(settings), .selected_addr(selected_addr),
    .device_enabled(device_enabled), .torch_mode(torch_mode), .flash_active(flash_active),
    .sink_channel_a(sink_channel_a), .sink_channel_b(sink_channel_b), .torch_off(torch_off),
    .inhibit_active(inhibit_active));

// File: sim/host_model.sv
// host controller model pulsing the single-wire control pin
`timescale 1ns/10ps
module host_model #(
    parameter int LATCH = 20
) (
    input wire logic mclk,
    output logic     ctrl_pin
);
    initial ctrl_pin = 1'h0;
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            ctrl_pin <= 1'h0;
            repeat (4) @(posedge mclk);
            ctrl_pin <= 1'h1;
            repeat (4) @(posedge mclk);
        end
        repeat (LATCH + 12) @(posedge mclk);
    endtask
    task automatic shut(input int c);
        ctrl_pin <= 1'h0;
        repeat (c) @(posedge mclk);
    endtask
endmodule

// File: sim/testbench.sv
// self-checking testbench for the flash link core
`timescale 1ns/10ps
module testbench;
    import flash_link_pkg::*;
    localparam logic [CNT_W-1:0] LAT = 17'h14;
    logic        mclk, rstn, ctrl, fl_in, inh, chk, en_m, locked, ce;
    settings_t   st;
    logic [1:0]  sel, addr;
    logic        en, tm, fa, sa, sb, toff, ia;
    logic [24:0] note_q[$];
    logic [24:0] want, seen;
    logic [31:0] lfsr;
    logic [3:0]  regs[4];
    int          err_total, check_count, cycles;
    flash_link_core #(.LATCH_CNT(LAT), .OFF_CNT(LAT)) dut (.mclk(mclk), .rstn(rstn), .clk_en(ce),
        .ctrl_pin(ctrl), .flash_trigger(fl_in), .flash_inhibit_pin(inh), .settings(st), .selected_addr(sel),
        .device_enabled(en), .torch_mode(tm), .flash_active(fa), .sink_channel_a(sa), .sink_channel_b(sb),
        .torch_off(toff), .inhibit_active(ia));
    host_model #(.LATCH(20)) host (.mclk(mclk), .ctrl_pin(ctrl));
    initial begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end
    function automatic logic [24:0] model(input logic f);
        logic [1:0] s;
        s = (regs[2] == 4'h1) ? 2'h1 : (regs[2] == 4'h2) ? 2'h2 : (regs[2] == 4'h3) ? 2'h3 : 2'h0;
        if (f) s = 2'h3;
        else if (!en_m || locked) s = 2'h0;
        return {addr, regs[0], regs[1], regs[2], regs[3], en_m, en_m && !f && !locked, s,
                regs[3] == 4'hF || regs[0] == 4'hF, f, f && inh};
    endfunction
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check_state(input logic f);
        @(posedge mclk);
        note_q.push_back(model(f));
        chk <= 1'h1;
        @(posedge mclk);
        chk <= 1'h0;
    endtask
    task automatic wr(input int n);
        host.send(n);
        en_m = 1'h1;
        if (n >= 17 && n <= 20) addr = 2'(n - 17);
        else if (n >= 1 && n <= 16) regs[addr] = 4'(n - 1);
    endtask
    task automatic clear();
        regs = '{default: 4'h0};
        addr = 2'h0;
        en_m = 1'h0;
        locked = 1'h0;
    endtask
    task automatic flash(input logic v, input logic i);
        fl_in <= v;
        inh <= v & i;
        repeat (12) @(posedge mclk);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            end_sim();
        end
        if (chk) begin
            want = note_q.pop_front();
            seen = {sel, st, en, tm, sa, sb, toff, fa, ia};
            check_count++;
            if (seen !== want) begin
                err_total++;
                $display("mismatch state expected %h seen %h", want, seen);
            end
        end
    end
    initial begin
        rstn = 1'h0;
        fl_in = 1'h0;
        inh = 1'h0;
        chk = 1'h0;
        ce = 1'h1;
        lfsr = 32'h7E8C;
        err_total = 0;
        check_count = 0;
        cycles = 0;
        clear();
        repeat (12) @(posedge mclk);
        rstn <= 1'h1;
        check_state(1'h0);
        wr(17);
        for (int i = 0; i < 3; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(int'(lfsr[3:0]) + 1);
            check_state(1'h0);
        end
        wr(16);
        check_state(1'h0);
        wr(18);
        wr(5);
        check_state(1'h0);
        wr(19);
        for (int d = 1; d <= 4; d++) begin
            wr(d);
            check_state(1'h0);
        end
        wr(20);
        wr(7);
        check_state(1'h0);
        wr(16);
        check_state(1'h0);
        ce <= 1'h0;
        host.send(5);
        ce <= 1'h1;
        check_state(1'h0);
        wr(22);
        check_state(1'h0);
        flash(1'h1, 1'h1);
        check_state(1'h1);
        flash(1'h0, 1'h0);
        regs[1] = 4'h0;
        locked = 1'h1;
        check_state(1'h0);
        host.shut(32);
        clear();
        check_state(1'h0);
        wr(3);
        check_state(1'h0);
        host.shut(32);
        clear();
        wr(18);
        lfsr = lfsr_next(lfsr);
        flash(1'h1, lfsr[0]);
        regs = '{4'h0, 4'h0, 4'h3, 4'h3};
        check_state(1'h1);
        flash(1'h0, 1'h0);
        locked = 1'h1;
        check_state(1'h0);
        end_sim();
    end
endmodule
